// ===== rtl/acmc_top.sv
// Purpose: Per-axis calibration and closed-loop mode control over APB.
// Assumes: Single 20 MHz clock; axis inputs from pins, synchronised here.
// Notes: Autocal after reset runs axes in order and blocks the bus.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "acmc_map.svh"
module acmc_top #(
  parameter int NAXES = 4,
  parameter int TIMEOUT_CYC = `ACMC_CALTIMEOUT_S * `ACMC_CLK_HZ,
  parameter int BLINK_CYC = `ACMC_BLINK_PERIOD_MS * (`ACMC_CLK_HZ / 1000),
  parameter int DARK_CYC = `ACMC_BLINK_DARK_MS * (`ACMC_CLK_HZ / 1000)
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Axis side
  input wire acmc_pkg::acmc_axis_in_t [NAXES-1:0] AXIS_I,
  input wire logic [NAXES-1:0][15:0] ZERO_OFS_I,
  input wire logic [NAXES-1:0] SAVED_CAL_I,
  output acmc_pkg::acmc_axis_out_t [NAXES-1:0] AXIS_O,
  // Status indicator and autocal state
  output logic LED_ON_O,
  output logic AUTOCAL_BUSY_O
);
  import acmc_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT} acmc_seq_t;

  acmc_axis_in_t [NAXES-1:0] in_meta;
  acmc_axis_in_t [NAXES-1:0] in_sync;
  logic [NAXES-1:0][2:0] mode;
  logic [NAXES-1:0] cal_seen;
  logic [NAXES-1:0][15:0] zofs;
  logic [NAXES-1:0] loop_on;
  logic mode_err;
  logic boot;
  logic boot_d1;
  logic boot_d2;
  logic restore_win;
  logic [NAXES-1:0] saved_meta;
  logic [NAXES-1:0] saved_sync;
  logic [NAXES-1:0] start_req;
  acmc_seq_t seq;
  logic [7:0] axis_idx;
  logic [31:0] tmo_cnt;
  logic [31:0] blink_cnt;
  logic apb_acc;
  logic blocked;

  // Decode the word index of an APB address
  function automatic logic [9:0] word_of(input logic [11:0] a);
    word_of = a[11:2];
  endfunction

  // Two-stage synchroniser for all axis pin inputs
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      in_meta <= '0;
      in_sync <= '0;
    end
    else
    begin
      in_meta <= AXIS_I;
      in_sync <= in_meta;
    end
  end

  // One-cycle marker right after reset release, plus delayed copies
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      boot <= 1'b1;
      boot_d1 <= 1'b1;
      boot_d2 <= 1'b1;
    end
    else
    begin
      boot <= 1'b0;
      boot_d1 <= boot;
      boot_d2 <= boot_d1;
    end
  end

  // Restore slot waits until the saved flags have crossed both stages
  assign restore_win = boot_d2 && !boot_d1;

  // Saved-result flags come from outside the clock domain
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      saved_meta <= '0;
      saved_sync <= '0;
    end
    else
    begin
      saved_meta <= SAVED_CAL_I;
      saved_sync <= saved_meta;
    end
  end

  // Bus is held off while autocal runs, so all register accesses wait
  assign blocked = (seq != ST_IDLE) || boot;
  assign apb_acc = PSEL_I && PENABLE_I && !blocked;

  // Mode store and error flag; reset value is mode 0
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      mode <= {NAXES{`ACMC_MODE_RST}};
      mode_err <= 1'b0;
    end
    else if (apb_acc && PWRITE_I && PREADY_O == 1'b0)
    begin
      unique case (word_of(PADDR_I))
        word_of(`ACMC_OFF_MODE):
        begin
          // Each axis field 3 bits at 4-bit pitch; all axes in one write
          for (int i = 0; i < NAXES; i++)
          begin
            if (PWDATA_I[4*i +: 3] <= `ACMC_MODE_MAX)
              mode[i] <= PWDATA_I[4*i +: 3];
            else
              mode_err <= 1'b1;
          end
        end
        word_of(`ACMC_OFF_STAT):
          if (PWDATA_I[0])
            mode_err <= 1'b0;
        default:
          mode_err <= mode_err;
      endcase
    end
  end

  // Autocal sequencer: axis by axis from axis 0
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      seq <= ST_IDLE;
      axis_idx <= 8'h00;
      tmo_cnt <= 32'h0;
    end
    else
    begin
      unique case (seq)
        ST_IDLE:
          if (boot)
          begin
            seq <= ST_START;
            axis_idx <= 8'h00;
          end
        ST_START:
        begin
          tmo_cnt <= 32'h0;
          if (axis_idx >= 8'(NAXES))
            seq <= ST_IDLE;
          else if (mode[axis_idx] == ACMC_M_AUTOCAL)
            seq <= ST_WAIT;
          else
            axis_idx <= axis_idx + 8'h01;
        end
        ST_WAIT:
        begin
          // Full time limit is consumed when nothing answers
          if (in_sync[axis_idx].cal_done ||
              in_sync[axis_idx].cal_timeout ||
              tmo_cnt >= 32'(TIMEOUT_CYC - 1))
          begin
            seq <= ST_START;
            axis_idx <= axis_idx + 8'h01;
          end
          else if (!in_sync[axis_idx].pause)
            tmo_cnt <= tmo_cnt + 32'h1;
        end
        default:
          seq <= ST_IDLE;
      endcase
    end
  end

  // Start pulse per axis at entry into its wait
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      start_req <= '0;
    else
      for (int i = 0; i < NAXES; i++)
        start_req[i] <= (seq == ST_START) && (axis_idx == 8'(i)) &&
                        (mode[i] == ACMC_M_AUTOCAL) &&
                        !in_sync[i].stop;
  end

  // Status indicator: short dark slot each period while busy
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      blink_cnt <= 32'h0;
      LED_ON_O <= 1'b1;
      AUTOCAL_BUSY_O <= 1'b0;
    end
    else
    begin
      AUTOCAL_BUSY_O <= (seq != ST_IDLE);
      if (seq == ST_IDLE)
      begin
        blink_cnt <= 32'h0;
        LED_ON_O <= 1'b1;
      end
      else
      begin
        blink_cnt <= (blink_cnt >= 32'(BLINK_CYC - 1)) ? 32'h0 :
                     blink_cnt + 32'h1;
        LED_ON_O <= (blink_cnt >= 32'(DARK_CYC));
      end
    end
  end

  // Per-axis behaviour
  genvar g;
  generate
    for (g = 0; g < NAXES; g++)
    begin : g_axis
      logic closed_ok;
      assign closed_ok = in_sync[g].enc_mask && in_sync[g].enc_present;

      // Calibration seen, zero offset capture, closed-loop latch
      always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
      begin
        if (!ARST_N_I)
        begin
          cal_seen[g] <= 1'b0;
          zofs[g] <= 16'h0000;
          loop_on[g] <= 1'b0;
        end
        else
        begin
          if (restore_win && mode[g] == ACMC_M_RESTORE && saved_sync[g])
            cal_seen[g] <= 1'b1;
          else if (in_sync[g].cal_done)
            cal_seen[g] <= 1'b1;
          if (in_sync[g].cal_done && mode[g] == ACMC_M_FIXZERO)
            zofs[g] <= ZERO_OFS_I[g];
          // Mask and encoder gate the loop; otherwise modes 1/2 close it, 0/4 after calibration, 3/5 keep it open
          if (!closed_ok)
            loop_on[g] <= 1'b0;
          else if (mode[g] == ACMC_M_FIXZERO ||
                   mode[g] == ACMC_M_LOOPUP)
            loop_on[g] <= 1'b1;
          else if (mode[g] == ACMC_M_CALZERO ||
                   mode[g] == ACMC_M_AUTOCAL)
            loop_on[g] <= cal_seen[g] || in_sync[g].cal_done;
          else if (mode[g] == ACMC_M_RESTORE ||
                   mode[g] == ACMC_M_READOUT)
            loop_on[g] <= 1'b0;
        end
      end

      // Registered axis command outputs
      always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
      begin
        if (!ARST_N_I)
          AXIS_O[g] <= '0;
        else
        begin
          AXIS_O[g].cal_start <= start_req[g];
          // Zero set on calibration except in mode 1
          AXIS_O[g].zero_motor <= in_sync[g].cal_done &&
                                  mode[g] != ACMC_M_FIXZERO;
          AXIS_O[g].zero_enc <= in_sync[g].cal_done &&
                                mode[g] == ACMC_M_READOUT;
          AXIS_O[g].loop_en <= loop_on[g];
          // Encoder wakes in modes 1/2 even with loop disabled
          AXIS_O[g].enc_active <= in_sync[g].enc_present &&
            (mode[g] == ACMC_M_FIXZERO || mode[g] == ACMC_M_LOOPUP ||
             (mode[g] == ACMC_M_READOUT && in_sync[g].enc_mask));
          AXIS_O[g].secvel_lift <= in_sync[g].axlen_known ||
            (mode[g] == ACMC_M_RESTORE && cal_seen[g]);
          AXIS_O[g].pos_corr <= mode[g] == ACMC_M_RESTORE &&
                                cal_seen[g];
          AXIS_O[g].vel_sel_cal <= in_sync[g].ext_mode;
          AXIS_O[g].vel_sel_sec <= !in_sync[g].axlen_known;
          AXIS_O[g].softlim_clear <= boot &&
                                     mode[g] == ACMC_M_RESTORE;
        end
      end
    end
  endgenerate

  // APB answer: one wait state, error on unmapped addresses
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      PREADY_O <= 1'b0;
      PRDATA_O <= 32'h0;
      PSLVERR_O <= 1'b0;
    end
    else if (apb_acc && !PREADY_O)
    begin
      PREADY_O <= 1'b1;
      PRDATA_O <= 32'h0;
      PSLVERR_O <= 1'b0;
      if (word_of(PADDR_I) == word_of(`ACMC_OFF_MODE))
      begin
        for (int i = 0; i < NAXES; i++)
          PRDATA_O[4*i +: 3] <= mode[i];
      end
      else if (word_of(PADDR_I) == word_of(`ACMC_OFF_STAT))
      begin
        PRDATA_O[0] <= mode_err;
        PRDATA_O[1] <= (seq != ST_IDLE);
        for (int i = 0; i < NAXES; i++)
        begin
          PRDATA_O[8+i] <= cal_seen[i];
          PRDATA_O[16+i] <= loop_on[i];
          PRDATA_O[24+i] <= in_sync[i].pos_src_enc;
        end
      end
      else if (word_of(PADDR_I) >= word_of(`ACMC_OFF_ZOFS0) &&
               word_of(PADDR_I) < word_of(`ACMC_OFF_ZOFS0) + 10'(NAXES))
        PRDATA_O[15:0] <= zofs[word_of(PADDR_I) -
                                word_of(`ACMC_OFF_ZOFS0)];
      else if (word_of(PADDR_I) != word_of(`ACMC_OFF_CTRL))
        PSLVERR_O <= 1'b1;
    end
    else
    begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
  end
  // Status bits from 24 up tell which position each axis query reports.
  // Host-side encoder setup is assumed.
endmodule
`default_nettype wire

// ===== rtl/acmc_map.svh
// Purpose: Offsets, mode limit, reset values and timing counts.
// Assumes: APB with 32-bit data, one word per register.
// Notes: Definitions only.
`ifndef ACMC_MAP_SVH
`define ACMC_MAP_SVH
`define ACMC_OFF_MODE 12'h000
`define ACMC_OFF_CTRL 12'h004
`define ACMC_OFF_STAT 12'h008
`define ACMC_OFF_ZOFS0 12'h010
`define ACMC_MODE_MAX 3'h5
`define ACMC_MODE_RST 3'h0
`define ACMC_CLK_HZ 20000000
`define ACMC_BLINK_PERIOD_MS 2500
`define ACMC_BLINK_DARK_MS 100
`define ACMC_CALTIMEOUT_S 60
`endif

// ===== rtl/acmc_pkg.sv
// Purpose: Types for the axis calibration mode block.
// Assumes: Up to eight axes.
// Notes: Mode codes follow the selection values 0 through 5.
package acmc_pkg;
  typedef enum logic [2:0] {
    ACMC_M_CALZERO = 3'h0,
    ACMC_M_FIXZERO = 3'h1,
    ACMC_M_LOOPUP = 3'h2,
    ACMC_M_READOUT = 3'h3,
    ACMC_M_AUTOCAL = 3'h4,
    ACMC_M_RESTORE = 3'h5
  } acmc_mode_t;
  typedef struct packed {
    logic stop;
    logic pause;
    logic cal_done;
    logic cal_timeout;
    logic enc_present;
    logic enc_mask;
    logic pos_src_enc;
    logic ext_mode;
    logic axlen_known;
  } acmc_axis_in_t;
  typedef struct packed {
    logic cal_start;
    logic zero_motor;
    logic zero_enc;
    logic loop_en;
    logic enc_active;
    logic secvel_lift;
    logic pos_corr;
    logic vel_sel_cal;
    logic vel_sel_sec;
    logic softlim_clear;
  } acmc_axis_out_t;
endpackage

// ===== testbench/acmc_checker.sv
// Purpose: Assertions on the APB and axis outputs of acmc_top.
// Assumes: Modes of axes 0 and 1 shadowed from accepted writes.
// Notes: Bound to every acmc_top instance.
`timescale 1ns/1ns
`default_nettype none
module acmc_checker
  import acmc_pkg::*;
#(
  parameter int NAXES = 2
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  // APB
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // Axis side and status
  input wire acmc_pkg::acmc_axis_out_t [NAXES-1:0] AXIS_O,
  input wire logic LED_ON_O,
  input wire logic AUTOCAL_BUSY_O
);
  logic [2:0] m0;
  logic [2:0] m1;
  // Mode shadow, one cycle behind the design
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      m0 <= 3'h0;
      m1 <= 3'h0;
    end
    else if (PREADY_O && PWRITE_I && PADDR_I == 12'h000)
    begin
      if (PWDATA_I[2:0] <= 3'h5)
        m0 <= PWDATA_I[2:0];
      if (PWDATA_I[6:4] <= 3'h5)
        m1 <= PWDATA_I[6:4];
    end
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!ARST_N_I);
  // Bus answers
  property p_ack;
    PREADY_O |-> $past(PSEL_I && PENABLE_I);
  endproperty
  a_ack: assert property (p_ack) else $error("ready without access");
  property p_ctrl;
    PREADY_O && !PWRITE_I && PADDR_I == 12'h004 |-> PRDATA_O == 32'h0;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("ctrl not zero");
  property p_unmap;
    PREADY_O && PADDR_I == 12'h0fc |-> PSLVERR_O;
  endproperty
  a_unmap: assert property (p_unmap) else $error("no slave error");
  // Power-up sequence blocks the host; LED lit when idle
  property p_block;
    AUTOCAL_BUSY_O |-> !PREADY_O;
  endproperty
  a_block: assert property (p_block) else $error("answer while busy");
  property p_led;
    !AUTOCAL_BUSY_O && $past(!AUTOCAL_BUSY_O) |-> LED_ON_O;
  endproperty
  a_led: assert property (p_led) else $error("led dark when idle");
  // Mode effects; the shadow must have held a cycle
  property p_fix;
    m0 == 3'h1 && $past(m0) == 3'h1 |-> !AXIS_O[0].zero_motor;
  endproperty
  a_fix: assert property (p_fix) else $error("zero moved in mode 1");
  property p_both;
    m1 == 3'h3 && $past(m1) == 3'h3 && AXIS_O[1].zero_motor
      |-> AXIS_O[1].zero_enc;
  endproperty
  a_both: assert property (p_both) else $error("encoder not zeroed");
  property p_open;
    (m1 == 3'h3 || m1 == 3'h5) && $past(m1) == m1 |-> !AXIS_O[1].loop_en;
  endproperty
  a_open: assert property (p_open) else $error("loop on in mode");
  c_wr: cover property (PREADY_O && PWRITE_I);
  c_err: cover property (PSLVERR_O);
  c_zero: cover property (AXIS_O[1].zero_enc);
endmodule
bind acmc_top acmc_checker #(.NAXES(NAXES)) u_chk (
  .CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .AXIS_O(AXIS_O), .LED_ON_O(LED_ON_O),
  .AUTOCAL_BUSY_O(AUTOCAL_BUSY_O));
`default_nettype wire

// ===== testbench/acmc_axis_model.sv
// Purpose: Axis drive model answering calibration moves.
// Assumes: Move takes DLY cycles, DLY at most 8.
// Notes: End flag stays up while a move is still requested.
`timescale 1ns/1ns
`default_nettype none
module acmc_axis_model
  import acmc_pkg::*;
#(
  parameter int N = 2,
  parameter int DLY = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Move requests from the block and the bench
  input wire acmc_pkg::acmc_axis_out_t [N-1:0] cmd_i,
  input wire logic [N-1:0] go_i,
  // End-of-move flags
  output logic [N-1:0] done_o
);
  logic [N-1:0][7:0] sh;
  // Shift chain, so a dropped request also drops the flag
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sh <= '0;
    else
      for (int i = 0; i < N; i++)
        sh[i] <= {sh[i][6:0], go_i[i] | cmd_i[i].cal_start};
  end
  // Flag taps the chain at the move length
  always_comb
    for (int i = 0; i < N; i++)
      done_o[i] = sh[i][DLY-1];
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Purpose: Self-checking bench for the calibration mode block.
// Assumes: Two axes, short timing counts, axis model on the far side.
// Notes: All register traffic goes over APB.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import acmc_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, led, busy, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0][15:0] zofs;
  logic [1:0] go, done, saved;
  acmc_axis_in_t [1:0] ain, ax;
  acmc_axis_out_t [1:0] aout;
  int n_fail = 0;
  int tests_run = 0;
  acmc_top #(.NAXES(2), .TIMEOUT_CYC(50), .BLINK_CYC(20), .DARK_CYC(4)) dut (
    .CLK_SYS_I(clk), .ARST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .AXIS_I(ax), .ZERO_OFS_I(zofs), .SAVED_CAL_I(saved), .AXIS_O(aout),
    .LED_ON_O(led), .AUTOCAL_BUSY_O(busy));
  acmc_axis_model #(.N(2), .DLY(5)) axm (.clk_i(clk), .rst_n_i(rst_n),
    .cmd_i(aout), .go_i(go), .done_o(done));
  // Axis levels with the model's end flags merged in
  always_comb
  begin
    ax = ain;
    ax[0].cal_done = done[0];
    ax[1].cal_done = done[1];
  end
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task stop_test;
    $display("Compares %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // A bounded wait that ran out
  task hung;
    n_fail++;
    $display("Error at %0t: wait timed out", $time);
    stop_test;
  endtask
  // One APB transfer, held until ready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Read just after the edge, so this is the value the edge sampled
    for (i = 0; i < 200; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 200)
      hung;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Re-read status until masked bits settle; sync delay is not fixed
  task poll(input logic [31:0] m, input logic [31:0] x);
    for (int i = 0; i < 30; i++)
    begin
      apb(1'b0, 12'h008, 32'h0);
      if ((q & m) === x)
        break;
    end
    chk(q & m, x);
  endtask
  // Main sequence
  initial
  begin
    int i;
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ain, go, zofs, saved} = '0;
    ain[0].enc_mask = 1'b1;
    ain[1].enc_mask = 1'b1;
    ain[0].enc_present = 1'b1;
    ain[1].enc_present = 1'b1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h0);
    chk(busy, 32'h0);
    chk(led, 32'h1);
    for (i = 0; i <= 5; i++)
    begin
      apb(1'b1, 12'h000, 32'(i));
      apb(1'b0, 12'h000, 32'h0);
      chk(q, 32'(i));
    end
    // Bad code on axis 0 refused, axis 1 still taken
    apb(1'b1, 12'h000, 32'h36);
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h35);
    apb(1'b0, 12'h008, 32'h0);
    chk(q & 32'h1, 32'h1);
    apb(1'b1, 12'h008, 32'h1);
    poll(32'h1, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    chk(e, 32'h1);
    // Axis 0 waits for its move, axis 1 closes the loop at once
    apb(1'b1, 12'h000, 32'h20);
    poll(32'h30300, 32'h20000);
    @(posedge clk);
    go <= 2'b11;
    poll(32'h30300, 32'h30300);
    chk(aout[0].zero_motor, 32'h1);
    chk(aout[1].zero_motor, 32'h1);
    @(posedge clk);
    go <= 2'b00;
    for (i = 0; i < 40 && aout[0].zero_motor | aout[1].zero_motor; i++)
      @(posedge clk);
    if (i == 40)
      hung;
    // Fixed zero on axis 0, readout on axis 1
    @(posedge clk);
    zofs[0] <= 16'h1234;
    ain[1].pos_src_enc <= 1'b1;
    apb(1'b1, 12'h000, 32'h31);
    poll(32'h30000, 32'h10000);
    @(posedge clk);
    go <= 2'b11;
    for (i = 0; i < 40 && aout[1].zero_motor !== 1'b1; i++)
      @(posedge clk);
    if (i == 40)
      hung;
    chk(aout[1].zero_enc, 32'h1);
    chk(aout[0].zero_motor, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(q & 32'hffff, 32'h1234);
    poll(32'h3000000, 32'h2000000);
    // Mask off: no loop, yet the encoder stays awake
    @(posedge clk);
    ain[0].enc_mask <= 1'b0;
    poll(32'h10000, 32'h0);
    chk(aout[0].enc_active, 32'h1);
    // Speed selection, descriptor length, and a missing encoder
    @(posedge clk);
    ain[1].ext_mode <= 1'b1;
    ain[1].axlen_known <= 1'b1;
    ain[0].enc_mask <= 1'b1;
    ain[0].enc_present <= 1'b0;
    saved <= 2'b11;
    repeat (5) @(posedge clk);
    chk(aout[1].vel_sel_cal, 32'h1);
    chk(aout[1].vel_sel_sec, 32'h0);
    chk(aout[0].vel_sel_sec, 32'h1);
    chk(aout[1].secvel_lift, 32'h1);
    chk(aout[0].secvel_lift, 32'h0);
    chk(aout[0].enc_active, 32'h0);
    chk(aout[0].loop_en, 32'h0);
    // Mode 5 on axis 1 keeps open loop and applies correction
    apb(1'b1, 12'h000, 32'h51);
    poll(32'h20000, 32'h0);
    chk(aout[1].pos_corr, 32'h1);
    // Mid-run reset: selection back to 0, nothing restored in mode 0
    @(posedge clk);
    go <= 2'b00;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h0);
    poll(32'h300, 32'h0);
    stop_test;
  end
endmodule
`default_nettype wire
